// >>> dv/prps_host_model.sv
`timescale 1ns/1ns
// power monitor and host side of the sequencer
module prps_host_model
(
   input wire logic ref_clk_in,
   input wire logic irq_pin_in,
   input wire logic park_req_in,
   output logic reset_out,
   output logic park_warning_n_out,
   output logic pll_locked_out,
   output logic host_ready_out
);
   int cnt = 0;

   initial
   begin
      reset_out = 1'b1;
      pll_locked_out = 1'b0;
      host_ready_out = 1'b0;
   end

   // reset held 16 edges, released with park high and clock stable
   always @(posedge ref_clk_in)
   begin
      cnt <= cnt + 1;
      if (cnt == 15)
         reset_out <= 1'b0;
      pll_locked_out <= !reset_out;
      // commands wait until the pin is seen low
      host_ready_out <= host_ready_out | (!reset_out & !irq_pin_in);
   end

   // early warning; reset stays released and clock runs meanwhile
   assign park_warning_n_out = !park_req_in;
endmodule : prps_host_model

// >>> dv/tb_prps_sequencer.sv
`timescale 1ns/1ns
module tb_prps_sequencer;
   import prps_pkg::*;
   localparam int PARK_N = 16;
   logic ref_clk_in = 1'b0;
   logic projector_on_in = 1'b1;
   logic core_power_good_in = 1'b1;
   logic park_req = 1'b0;
   logic reset_in, park_warning_n_in, pll_locked_in, host_ready, irq_pin;
   logic host_irq_out, host_irq_oe_n_out, led_select_0_out, led_select_1_out;
   logic led_select_oe_n_out, flash_load_busy_out, mirror_park_out;
   logic projecting_out, low_power_out;
   prps_flash_pins_t flash_pins_out;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 98840;
   int n;
   int exp_on = 1;
   int hits;

   // pull-up: the pin reads high whenever undriven
   assign irq_pin = host_irq_oe_n_out ? 1'b1 : host_irq_out;

   initial
   begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   prps_sequencer #(.PLL_LOCK_CYC(4), .FLASH_LOAD_CYC(8), .PARK_CYC(PARK_N))
   prps_sequencer_inst (.ref_clk_in, .reset_in, .projector_on_in, .park_warning_n_in,
      .core_power_good_in, .pll_locked_in, .host_irq_out, .host_irq_oe_n_out,
      .led_select_0_out, .led_select_1_out, .led_select_oe_n_out, .flash_pins_out,
      .flash_load_busy_out, .mirror_park_out, .projecting_out, .low_power_out);

   prps_host_model prps_host_model_inst (.ref_clk_in, .irq_pin_in(irq_pin),
      .park_req_in(park_req), .reset_out(reset_in), .park_warning_n_out(park_warning_n_in),
      .pll_locked_out(pll_locked_in), .host_ready_out(host_ready));

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   task automatic check(input string s, input logic [5:0] e, input logic [5:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask : check

   function automatic logic sig(input int k);
      case (k)
         0: return host_irq_oe_n_out;
         1: return irq_pin;
         2: return flash_load_busy_out;
         3: return mirror_park_out;
         4: return projecting_out;
         default: return low_power_out;
      endcase
   endfunction : sig

   // bounded wait; c counts the edges it took
   task automatic wait_for(input int k, input logic v, output int c);
      c = 0;
      while (sig(k) !== v)
      begin
         @(posedge ref_clk_in);
         #1;
         c++;
         if (c > 4000)
         begin
            num_errors++;
            $display("ERROR wait %0d expected %b seen %b", k, v, sig(k));
            final_report();
         end
      end
   endtask : wait_for

   initial
   begin
      repeat (8) @(posedge ref_clk_in);
      #1;
      check("irq_oe_n", 1, host_irq_oe_n_out);
      check("led_oe_n", 1, led_select_oe_n_out);
      check("flash", PRPS_FLASH_HIZ, flash_pins_out);
      check("outs", 0, {led_select_0_out, led_select_1_out, flash_load_busy_out,
         mirror_park_out, projecting_out, low_power_out});
      $display("test reset done");
      wait_for(0, 0, n);
      check("irq", 1, irq_pin);
      check("host idle", 0, host_ready);
      wait_for(2, 1, n);
      check("pll first", 1, n >= 3);
      check("cs_n", 0, flash_pins_out.cs_n);
      check("led_oe_n", 0, led_select_oe_n_out);
      wait_for(1, 0, n);
      check("busy", 0, flash_load_busy_out);
      check("run", exp_on, projecting_out);
      check("flash", PRPS_FLASH_IDLE, flash_pins_out);
      $display("test init done");
      // short lows, the last one just under the filter length
      for (int i = 0; i < 4; i++)
      begin
         n = (i == 3) ? 18 : 1 + {$random(seed)} % 15;
         @(posedge ref_clk_in);
         park_req <= 1'b1;
         repeat (n) @(posedge ref_clk_in);
         park_req <= 1'b0;
         // watch every edge: a slipped filter would park and recover inside the gap
         hits = 0;
         repeat (30)
         begin
            @(posedge ref_clk_in);
            #1;
            if (mirror_park_out !== 1'b0)
               hits++;
         end
         check("glitch", 0, hits != 0);
      end
      check("host ready", 1, host_ready);
      @(posedge ref_clk_in);
      park_req <= 1'b1;
      wait_for(3, 1, n);
      // warning held through the park; the count runs down through zero, so PARK_N + 1
      wait_for(3, 0, n);
      check("park len", PARK_N + 1, n);
      @(posedge ref_clk_in);
      park_req <= 1'b0;
      wait_for(4, 1, n);
      $display("test park done");
      @(posedge ref_clk_in);
      projector_on_in <= 1'b0;
      exp_on = 0;
      wait_for(3, 1, n);
      wait_for(5, 1, n);
      check("run", exp_on, projecting_out);
      $display("test off done");
      @(posedge ref_clk_in);
      core_power_good_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      #1;
      check("oe_n", 6'h1f, {host_irq_oe_n_out, led_select_oe_n_out, flash_pins_out.sclk_oe_n,
         flash_pins_out.sdo_oe_n, flash_pins_out.cs_oe_n});
      $display("test core power done");
      final_report();
   end
endmodule : tb_prps_sequencer

// >>> hdl/prps_pkg.sv
package prps_pkg;
   // park filter: transitions shorter than 150 ns are ignored
   localparam int unsigned PRPS_CLK_MHZ = 125;
   localparam int unsigned PRPS_PARK_FILT_NS = 150;
   localparam int unsigned PRPS_PARK_FILT_CYC = (PRPS_PARK_FILT_NS * PRPS_CLK_MHZ + 999) / 1000;
   // park must finish inside the 40 us the system guarantees
   localparam int unsigned PRPS_PARK_WIN_US = 40;
   localparam int unsigned PRPS_PARK_WIN_CYC = PRPS_PARK_WIN_US * PRPS_CLK_MHZ;
   localparam int unsigned PRPS_CNT_W = 16;
   // plain defaults for steps whose length the device does not fix
   localparam int unsigned PRPS_PLL_LOCK_CYC_DEF = 64;
   localparam int unsigned PRPS_FLASH_LOAD_CYC_DEF = 256;
   localparam int unsigned PRPS_PARK_CYC_DEF = 1000;
   localparam logic [PRPS_CNT_W-1:0] PRPS_CNT_ZERO = 16'h0000;
   localparam logic [PRPS_CNT_W-1:0] PRPS_CNT_ONE = 16'h0001;
   localparam logic [7:0] PRPS_FILT_ZERO = 8'h00;

   typedef enum logic [6:0] {
      PRPS_ST_RESET = 7'h01,
      PRPS_ST_OFF = 7'h02,
      PRPS_ST_PLL = 7'h04,
      PRPS_ST_LOAD = 7'h08,
      PRPS_ST_RUN = 7'h10,
      PRPS_ST_PARK = 7'h20,
      PRPS_ST_PARKED = 7'h40
   } prps_state_t;

   // flash pin group: value plus active-low output enable
   typedef struct packed {
      logic sclk;
      logic sdo;
      logic cs_n;
      logic sclk_oe_n;
      logic sdo_oe_n;
      logic cs_oe_n;
   } prps_flash_pins_t;

   localparam prps_flash_pins_t PRPS_FLASH_HIZ = 6'h3f;
   localparam prps_flash_pins_t PRPS_FLASH_IDLE = 6'h08;
endpackage : prps_pkg

// >>> hdl/prps_sequencer.sv
`timescale 1ns/1ns
// Summary of operation
// - projector_on high: power up, project image
// - projector_on low: power down to microwatt state
// - in reset: outputs inactive, bidirectionals input
// - in reset: led selects, flash pins tri-stated
// - after reset: lock PLL, then load flash
// - reset release makes all pins active
// - after release drive host interrupt high
// - init done drives host interrupt low
// - park warning low parks the mirror array
// - core power lost: io outputs high impedance
// - park input filtered against 150 ns edges
module prps_sequencer
   import prps_pkg::*;
#(
   parameter int unsigned PLL_LOCK_CYC = PRPS_PLL_LOCK_CYC_DEF,
   parameter int unsigned FLASH_LOAD_CYC = PRPS_FLASH_LOAD_CYC_DEF,
   parameter int unsigned PARK_CYC = PRPS_PARK_CYC_DEF
)
(
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic projector_on_in,
   input wire logic park_warning_n_in,
   input wire logic core_power_good_in,
   input wire logic pll_locked_in,
   output logic host_irq_out,
   output logic host_irq_oe_n_out,
   output logic led_select_0_out,
   output logic led_select_1_out,
   output logic led_select_oe_n_out,
   output prps_flash_pins_t flash_pins_out,
   output logic flash_load_busy_out,
   output logic mirror_park_out,
   output logic projecting_out,
   output logic low_power_out
);

   // reset_in is system_reset_n inverted and synchronised by the pad ring
   logic [1:0] on_sync_reg, on_sync_next;
   logic [1:0] park_sync_reg, park_sync_next;
   logic [1:0] pwr_sync_reg, pwr_sync_next;
   logic [1:0] lock_sync_reg, lock_sync_next;

   // two-flop synchronisers; only stage 1 is read by logic
   always_comb
   begin
      on_sync_next = {on_sync_reg[0], projector_on_in};
      park_sync_next = {park_sync_reg[0], park_warning_n_in};
      pwr_sync_next = {pwr_sync_reg[0], core_power_good_in};
      lock_sync_next = {lock_sync_reg[0], pll_locked_in};
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         on_sync_reg <= 2'h0;
         park_sync_reg <= 2'h3;
         pwr_sync_reg <= 2'h0;
         lock_sync_reg <= 2'h0;
      end
      else
      begin
         on_sync_reg <= on_sync_next;
         park_sync_reg <= park_sync_next;
         pwr_sync_reg <= pwr_sync_next;
         lock_sync_reg <= lock_sync_next;
      end
   end

   // park glitch filter: new level must hold PRPS_PARK_FILT_CYC cycles
   logic park_filt_reg, park_filt_next;
   logic [7:0] filt_cnt_reg, filt_cnt_next;

   always_comb
   begin
      park_filt_next = park_filt_reg;
      filt_cnt_next = PRPS_FILT_ZERO;
      if (park_sync_reg[1] != park_filt_reg)
      begin
         filt_cnt_next = filt_cnt_reg + 8'h01;
         if (filt_cnt_reg == 8'(PRPS_PARK_FILT_CYC - 1))
         begin
            park_filt_next = park_sync_reg[1];
            filt_cnt_next = PRPS_FILT_ZERO;
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         park_filt_reg <= 1'b1;
         filt_cnt_reg <= PRPS_FILT_ZERO;
      end
      else
      begin
         park_filt_reg <= park_filt_next;
         filt_cnt_reg <= filt_cnt_next;
      end
   end

   // main sequence
   prps_state_t state_reg, state_next;
   logic [PRPS_CNT_W-1:0] cnt_reg, cnt_next;
   logic want_on;
   logic cnt_done;

   assign want_on = on_sync_reg[1] && park_filt_reg;
   assign cnt_done = (cnt_reg == PRPS_CNT_ZERO);

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_done ? PRPS_CNT_ZERO : cnt_reg - PRPS_CNT_ONE;
      unique case (state_reg)
         PRPS_ST_RESET:
         begin
            state_next = PRPS_ST_PLL;
            cnt_next = PRPS_CNT_W'(PLL_LOCK_CYC);
         end
         PRPS_ST_PLL:
            if (cnt_done && lock_sync_reg[1])
            begin
               state_next = PRPS_ST_LOAD;
               cnt_next = PRPS_CNT_W'(FLASH_LOAD_CYC);
            end
         PRPS_ST_LOAD:
            if (cnt_done)
               state_next = want_on ? PRPS_ST_RUN : PRPS_ST_OFF;
         PRPS_ST_OFF:
            if (want_on)
               state_next = PRPS_ST_RUN;
         PRPS_ST_RUN:
            if (!want_on)
            begin
               state_next = PRPS_ST_PARK;
               cnt_next = PRPS_CNT_W'(PARK_CYC);
            end
         PRPS_ST_PARK:
            if (cnt_done)
               state_next = PRPS_ST_PARKED;
         PRPS_ST_PARKED:
            if (want_on)
               state_next = PRPS_ST_RUN;
            else
               state_next = PRPS_ST_OFF;
         default:
            state_next = PRPS_ST_RESET;
      endcase
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         state_reg <= PRPS_ST_RESET;
         cnt_reg <= PRPS_CNT_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // registered pin drive; irq, led select and flash pins float if core power drops
   logic io_live;
   logic irq_next, irq_oe_n_next, led_oe_n_next, busy_next, park_next, proj_next, lowp_next;
   prps_flash_pins_t flash_next;

   assign io_live = pwr_sync_reg[1] && (state_next != PRPS_ST_RESET);

   always_comb
   begin
      irq_next = 1'b1;
      irq_oe_n_next = !io_live;
      led_oe_n_next = !io_live;
      flash_next = io_live ? PRPS_FLASH_IDLE : PRPS_FLASH_HIZ;
      busy_next = (state_next == PRPS_ST_LOAD);
      park_next = (state_next == PRPS_ST_PARK);
      proj_next = (state_next == PRPS_ST_RUN);
      lowp_next = (state_next == PRPS_ST_OFF);
      if (state_next == PRPS_ST_LOAD)
         flash_next.cs_n = 1'b0;
      if (state_next inside {PRPS_ST_OFF, PRPS_ST_RUN, PRPS_ST_PARK, PRPS_ST_PARKED})
         irq_next = 1'b0;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
      begin
         host_irq_out <= 1'b1;
         host_irq_oe_n_out <= 1'b1;
         led_select_oe_n_out <= 1'b1;
         flash_pins_out <= PRPS_FLASH_HIZ;
         flash_load_busy_out <= 1'b0;
         mirror_park_out <= 1'b0;
         projecting_out <= 1'b0;
         low_power_out <= 1'b0;
         led_select_0_out <= 1'b0;
         led_select_1_out <= 1'b0;
      end
      else
      begin
         host_irq_out <= irq_next;
         host_irq_oe_n_out <= irq_oe_n_next;
         led_select_oe_n_out <= led_oe_n_next;
         flash_pins_out <= flash_next;
         flash_load_busy_out <= busy_next;
         mirror_park_out <= park_next;
         projecting_out <= proj_next;
         low_power_out <= lowp_next;
         led_select_0_out <= 1'b0;
         led_select_1_out <= 1'b0;
      end
   end

   // assertions
   property p_irq_float_in_reset;
      @(posedge ref_clk_in) reset_in |=> host_irq_oe_n_out && flash_pins_out == PRPS_FLASH_HIZ;
   endproperty
   a_irq_float_in_reset: assert property (p_irq_float_in_reset) else $error("pins driven in reset");

   // core power needs two edges through its synchroniser before pins go live
   sequence s_release;
      $fell(reset_in) ##2 pwr_sync_reg[1];
   endsequence
   property p_irq_high_after_release;
      @(posedge ref_clk_in) disable iff (reset_in)
         s_release |=> !host_irq_oe_n_out && host_irq_out;
   endproperty
   a_irq_high_after_release: assert property (p_irq_high_after_release) else $error("irq not high");

   property p_pll_before_load;
      @(posedge ref_clk_in) disable iff (reset_in)
         $rose(flash_load_busy_out) |-> $past(lock_sync_reg[1]);
   endproperty
   a_pll_before_load: assert property (p_pll_before_load) else $error("load before lock");

   property p_irq_low_when_done;
      @(posedge ref_clk_in) disable iff (reset_in)
         (state_reg == PRPS_ST_LOAD && cnt_done) |=> !host_irq_out;
   endproperty
   a_irq_low_when_done: assert property (p_irq_low_when_done) else $error("irq not low");

   property p_park_on_warning;
      @(posedge ref_clk_in) disable iff (reset_in)
         (state_reg == PRPS_ST_RUN && !park_filt_reg) |=> mirror_park_out;
   endproperty
   a_park_on_warning: assert property (p_park_on_warning) else $error("no park");

   property p_filter_glitch;
      @(posedge ref_clk_in) disable iff (reset_in)
         $changed(park_filt_reg) |-> $past(park_sync_reg[1]) == park_filt_reg &&
            $past(park_sync_reg[1], PRPS_PARK_FILT_CYC) == park_filt_reg;
   endproperty
   a_filter_glitch: assert property (p_filter_glitch) else $error("filter slip");

   property p_off_low_power;
      @(posedge ref_clk_in) disable iff (reset_in)
         (state_reg == PRPS_ST_OFF && !want_on) |=> low_power_out && !projecting_out;
   endproperty
   a_off_low_power: assert property (p_off_low_power) else $error("not low power");

   property p_on_projects;
      @(posedge ref_clk_in) disable iff (reset_in)
         (state_reg == PRPS_ST_OFF && want_on) |=> projecting_out;
   endproperty
   a_on_projects: assert property (p_on_projects) else $error("not projecting");

   property p_core_loss_hiz;
      @(posedge ref_clk_in) disable iff (reset_in)
         !pwr_sync_reg[1] |=> host_irq_oe_n_out && led_select_oe_n_out;
   endproperty
   a_core_loss_hiz: assert property (p_core_loss_hiz) else $error("driven without core");

   // helper: cycles the park flag has stood, for the window check
   // margin of 4 covers synchroniser and state latency ahead of the park
   localparam logic [PRPS_CNT_W-1:0] PARK_LIMIT =
      PRPS_CNT_W'(PRPS_PARK_WIN_CYC - PRPS_PARK_FILT_CYC - 4);
   logic [PRPS_CNT_W-1:0] park_len_reg, park_len_next;

   always_comb
   begin
      park_len_next = mirror_park_out ? park_len_reg + PRPS_CNT_ONE : PRPS_CNT_ZERO;
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (reset_in)
         park_len_reg <= PRPS_CNT_ZERO;
      else
         park_len_reg <= park_len_next;
   end

   property p_park_fits_window;
      @(posedge ref_clk_in) disable iff (reset_in)
         mirror_park_out |-> park_len_reg < PARK_LIMIT;
   endproperty
   a_park_fits_window: assert property (p_park_fits_window) else $error("park too long");

endmodule : prps_sequencer
